// file: core/pbs_pkg.sv
/*
 Package for the power button state control block: timing counts and state encodings.
 Assumes a 250 MHz always-on standby clock.
*/
package pbs_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned SHORT_MAX_S = 4;
	localparam int unsigned FORCE_OFF_S = 6;
	localparam longint unsigned SHORT_CYC = longint'(SHORT_MAX_S) * CLK_MHZ * 1000000;
	localparam longint unsigned FORCE_CYC = longint'(FORCE_OFF_S) * CLK_MHZ * 1000000 + 1;
	localparam int unsigned CNT_W = 32;
	localparam logic [1:0] SLP_MEM = 2'h1;
	localparam logic [1:0] SLP_DISK = 2'h2;
	localparam logic [1:0] SLP_NONE = 2'h0;
	localparam logic [3:0] PWR_ALL_ON = 4'hf;
	localparam logic [3:0] PWR_MEM_ONLY = 4'h9;
	localparam logic [3:0] PWR_WAKE_ONLY = 4'h8;
	typedef enum logic [1:0] {
		PBS_SOFT_OFF,
		PBS_WORKING,
		PBS_SLEEP
	} pbs_state_e;
endpackage

// file: core/pbs_press_timer.sv
/*
 Press duration timer: measures how long the switch is held.
 Assumes the switch input is debounced and synchronous to mclk_i.
*/
`timescale 1ns/1ps
module pbs_press_timer #(
	parameter longint unsigned SHORT_CYC = pbs_pkg::SHORT_CYC,
	parameter longint unsigned FORCE_CYC = pbs_pkg::FORCE_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic btn_i,
	output logic short_rel_o,
	output logic force_o
);
	logic [pbs_pkg::CNT_W-1:0] cnt_r;
	logic btn_d_r;
	logic fired_r;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cnt_r <= '0;
			btn_d_r <= 1'b0;
		end else if (ce_i) begin
			btn_d_r <= btn_i;
			if (!btn_i)
				cnt_r <= '0;
			else if (cnt_r != '1)
				cnt_r <= cnt_r + 1'b1;
		end
	end

	// Long hold fires once while still held; release afterwards is swallowed
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			fired_r <= 1'b0;
			force_o <= 1'b0;
			short_rel_o <= 1'b0;
		end else if (ce_i) begin
			force_o <= btn_i && !fired_r && (longint'(cnt_r) + 1 >= FORCE_CYC);
			if (btn_i && longint'(cnt_r) + 1 >= FORCE_CYC)
				fired_r <= 1'b1;
			else if (!btn_i)
				fired_r <= 1'b0;
			short_rel_o <= btn_d_r && !btn_i && !fired_r;
		end
	end

	// Held count at release decides; between the two limits it is still short
	chk_mid_hold_short: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && btn_d_r && !btn_i && cnt_r >= SHORT_CYC && longint'(cnt_r) < FORCE_CYC |=> short_rel_o)
		else $error("Mid-length hold not short");
	chk_no_early_force: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && btn_i && longint'(cnt_r) + 1 < FORCE_CYC |=> !force_o)
		else $error("Forced off before hold limit");
endmodule // pbs_press_timer

// file: core/pbs_ctrl.sv
/*
 Power button state control: system state tracker for switch presses,
 OS soft-off/sleep requests and wake events. Runs on always-on standby clock;
 rst_i is asserted on loss of all power.
*/
`timescale 1ns/1ps
// What this block does
// - Short press from soft off or sleep goes to working.
// - Hold over six seconds in working or sleep forces soft off.
// - Short press while working sleeps or soft-offs per setting.
// - Press result depends on current state and measured hold time.
// - Suspend to RAM keeps memory rail on, processor off, wake logic on.
// - Suspend to disk removes processor power, keeps only wake logic.
// - Soft off keeps no context; leaving it demands a cold boot.
// - OS soft-off request powers the system off without the switch.
// - One switch input serves as both power and sleep control.
// - Enabled wake event in sleep returns quickly to working.
module pbs_ctrl #(
	parameter longint unsigned SHORT_CYC = pbs_pkg::SHORT_CYC,
	parameter longint unsigned FORCE_CYC = pbs_pkg::FORCE_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic btn_i,
	input wire logic btn_sleep_cfg_i,
	input wire logic btn_sleep_disk_i,
	input wire logic os_off_req_i,
	input wire logic os_sleep_req_i,
	input wire logic os_sleep_disk_i,
	input wire logic wake_req_i,
	input wire logic wake_en_i,
	output logic [1:0] sys_state_o,
	output logic [1:0] sleep_type_o,
	output logic [3:0] rail_en_o,
	output logic cold_boot_o,
	output logic resume_o
);
	// ---------------------------------------------
	// Press measurement
	// ---------------------------------------------
	logic short_rel;
	logic force_off;

	pbs_press_timer #(
		.SHORT_CYC(SHORT_CYC),
		.FORCE_CYC(FORCE_CYC)
	) u_timer (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.btn_i(btn_i),
		.short_rel_o(short_rel),
		.force_o(force_off)
	);

	// ---------------------------------------------
	// State tracker
	// ---------------------------------------------
	pbs_pkg::pbs_state_e st_r;
	pbs_pkg::pbs_state_e st_nxt;
	logic [1:0] slp_r;
	logic [1:0] slp_nxt;

	always_comb begin
		st_nxt = st_r;
		slp_nxt = slp_r;
		case (st_r)
			pbs_pkg::PBS_SOFT_OFF: begin
				if (short_rel)
					st_nxt = pbs_pkg::PBS_WORKING;
			end
			pbs_pkg::PBS_WORKING: begin
				if (force_off) begin
					st_nxt = pbs_pkg::PBS_SOFT_OFF;
				end else if (short_rel) begin
					if (btn_sleep_cfg_i) begin
						st_nxt = pbs_pkg::PBS_SLEEP;
						slp_nxt = btn_sleep_disk_i ? pbs_pkg::SLP_DISK : pbs_pkg::SLP_MEM;
					end else begin
						st_nxt = pbs_pkg::PBS_SOFT_OFF;
					end
				end else if (os_off_req_i) begin
					st_nxt = pbs_pkg::PBS_SOFT_OFF;
				end else if (os_sleep_req_i) begin
					st_nxt = pbs_pkg::PBS_SLEEP;
					slp_nxt = os_sleep_disk_i ? pbs_pkg::SLP_DISK : pbs_pkg::SLP_MEM;
				end
			end
			pbs_pkg::PBS_SLEEP: begin
				if (force_off)
					st_nxt = pbs_pkg::PBS_SOFT_OFF;
				else if (short_rel || (wake_req_i && wake_en_i))
					st_nxt = pbs_pkg::PBS_WORKING;
			end
			default: st_nxt = pbs_pkg::PBS_SOFT_OFF;
		endcase
		if (st_nxt != pbs_pkg::PBS_SLEEP)
			slp_nxt = pbs_pkg::SLP_NONE;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st_r <= pbs_pkg::PBS_SOFT_OFF;
			slp_r <= pbs_pkg::SLP_NONE;
		end else if (ce_i) begin
			st_r <= st_nxt;
			slp_r <= slp_nxt;
		end
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			sys_state_o <= 2'(pbs_pkg::PBS_SOFT_OFF);
			sleep_type_o <= pbs_pkg::SLP_NONE;
			rail_en_o <= pbs_pkg::PWR_WAKE_ONLY;
			cold_boot_o <= 1'b0;
			resume_o <= 1'b0;
		end else if (ce_i) begin
			sys_state_o <= st_nxt;
			sleep_type_o <= slp_nxt;
			case (st_nxt)
				pbs_pkg::PBS_WORKING: rail_en_o <= pbs_pkg::PWR_ALL_ON;
				pbs_pkg::PBS_SLEEP: rail_en_o <= (slp_nxt == pbs_pkg::SLP_MEM) ?
					pbs_pkg::PWR_MEM_ONLY : pbs_pkg::PWR_WAKE_ONLY;
				default: rail_en_o <= pbs_pkg::PWR_WAKE_ONLY;
			endcase
			// Disk resume also reboots; only RAM context survives
			cold_boot_o <= (st_r != pbs_pkg::PBS_WORKING) && (st_nxt == pbs_pkg::PBS_WORKING) &&
				!(st_r == pbs_pkg::PBS_SLEEP && slp_r == pbs_pkg::SLP_MEM);
			resume_o <= (st_r == pbs_pkg::PBS_SLEEP) && (st_nxt == pbs_pkg::PBS_WORKING);
		end
	end

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	sequence s_force_in_run;
		force_off && ce_i && (st_r != pbs_pkg::PBS_SOFT_OFF);
	endsequence

	sequence s_short_in_work;
		ce_i && short_rel && !force_off && st_r == pbs_pkg::PBS_WORKING;
	endsequence

	sequence s_os_sleep_in_work;
		ce_i && os_sleep_req_i && !os_off_req_i && !short_rel && !force_off && st_r == pbs_pkg::PBS_WORKING;
	endsequence

	sequence s_sleep_exit;
		ce_i && !force_off && (short_rel || (wake_req_i && wake_en_i)) && st_r == pbs_pkg::PBS_SLEEP;
	endsequence

	chk_force_off_state: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_force_in_run |=> st_r == pbs_pkg::PBS_SOFT_OFF)
		else $error("Forced off not taken");
	chk_off_short_on: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && short_rel && st_r == pbs_pkg::PBS_SOFT_OFF |=> st_r == pbs_pkg::PBS_WORKING && cold_boot_o)
		else $error("Short press did not power on");
	chk_wake_resume: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && !force_off && wake_req_i && wake_en_i && st_r == pbs_pkg::PBS_SLEEP |=> resume_o)
		else $error("Wake event lost");
	chk_ram_rails: assert property (@(posedge mclk_i) disable iff (rst_i)
		sys_state_o == 2'(pbs_pkg::PBS_SLEEP) && sleep_type_o == pbs_pkg::SLP_MEM |-> rail_en_o == pbs_pkg::PWR_MEM_ONLY)
		else $error("RAM rail wrong in sleep");
	chk_disk_rails: assert property (@(posedge mclk_i) disable iff (rst_i)
		sleep_type_o == pbs_pkg::SLP_DISK |-> rail_en_o == pbs_pkg::PWR_WAKE_ONLY)
		else $error("Disk sleep rails wrong");
	chk_os_off: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && os_off_req_i && !short_rel && !force_off && st_r == pbs_pkg::PBS_WORKING
		|=> sys_state_o == 2'(pbs_pkg::PBS_SOFT_OFF))
		else $error("OS off ignored");
	chk_short_work: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_short_in_work
		|=> st_r == ($past(btn_sleep_cfg_i) ? pbs_pkg::PBS_SLEEP : pbs_pkg::PBS_SOFT_OFF))
		else $error("Short press in working wrong");
	chk_no_force_short: assert property (@(posedge mclk_i) disable iff (rst_i)
		!(short_rel && force_off))
		else $error("Short and forced press together");
	chk_short_sleep_type: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_short_in_work ##0 btn_sleep_cfg_i
		|=> sleep_type_o == ($past(btn_sleep_disk_i) ? pbs_pkg::SLP_DISK : pbs_pkg::SLP_MEM))
		else $error("Switch sleep type wrong");
	chk_os_sleep_go: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_os_sleep_in_work
		|=> sys_state_o == 2'(pbs_pkg::PBS_SLEEP) &&
		sleep_type_o == ($past(os_sleep_disk_i) ? pbs_pkg::SLP_DISK : pbs_pkg::SLP_MEM))
		else $error("OS sleep request not carried out");
	chk_os_refused: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && !short_rel && (os_off_req_i || os_sleep_req_i) && st_r == pbs_pkg::PBS_SOFT_OFF
		|=> st_r == pbs_pkg::PBS_SOFT_OFF)
		else $error("OS request taken outside working");
	chk_sleep_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		ce_i && !short_rel && !force_off && !(wake_req_i && wake_en_i) && st_r == pbs_pkg::PBS_SLEEP
		|=> st_r == pbs_pkg::PBS_SLEEP)
		else $error("Sleep left without cause");
	// RAM context survives, so leaving RAM sleep must not reboot
	chk_ram_resume: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_sleep_exit ##0 slp_r == pbs_pkg::SLP_MEM |=> resume_o && !cold_boot_o)
		else $error("RAM resume rebooted");
	chk_disk_resume: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_sleep_exit ##0 slp_r == pbs_pkg::SLP_DISK |=> resume_o && cold_boot_o)
		else $error("Disk resume without cold boot");
	// Pulses hold while ce_i is low; consumers must gate on ce_i as well
	chk_boot_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
		cold_boot_o && ce_i |=> !cold_boot_o)
		else $error("Cold boot pulse too long");
	chk_ce_freeze: assert property (@(posedge mclk_i) disable iff (rst_i)
		!ce_i |=> $stable(st_r) && $stable(sys_state_o) && $stable(rail_en_o))
		else $error("State moved with clock enable low");

	// ---------------------------------------------
	// Output encoding checks
	// ---------------------------------------------
	chk_off_rails: assert property (@(posedge mclk_i) disable iff (rst_i)
		sys_state_o == 2'(pbs_pkg::PBS_SOFT_OFF)
		|-> rail_en_o == pbs_pkg::PWR_WAKE_ONLY && sleep_type_o == pbs_pkg::SLP_NONE)
		else $error("Soft off rails wrong");
	chk_work_rails: assert property (@(posedge mclk_i) disable iff (rst_i)
		sys_state_o == 2'(pbs_pkg::PBS_WORKING) |-> rail_en_o == pbs_pkg::PWR_ALL_ON)
		else $error("Working rails not all on");
endmodule // pbs_ctrl

// file: verification/pbs_panel_model.sv
/*
 Front panel switch model: holds the switch for a set number of cycles.
 Assumes one standby clock shared with the block.
*/
`timescale 1ns/1ps
module pbs_panel_model (
	input wire logic mclk_i,
	input wire logic go_i,
	input wire logic [7:0] len_i,
	output logic btn_o,
	output logic busy_o
);
	int n = 0;
	// Extra idle cycles so the block sees the release before busy drops
	always @(posedge mclk_i) begin
		if (n == 0 && go_i)
			n <= len_i + 6;
		else if (n != 0)
			n <= n - 1;
	end
	// One switch line only, released level is low
	initial btn_o = 1'b0;
	always @(negedge mclk_i) btn_o <= (n > 6);
	assign busy_o = (n != 0);
endmodule // pbs_panel_model

// file: verification/test_power_button_state_control.sv
/*
 Testbench for the power button state control block.
 Assumes shortened press counts of 40 and 61 cycles.
*/
`timescale 1ns/1ps
module test_power_button_state_control;
	logic mclk_i = 0, rst_i = 1, ce = 1, cfg = 0, sdisk = 0, off_req = 0, slp_req = 0;
	logic os_disk = 0, wake = 0, wen = 0, go = 0;
	logic [7:0] len = 0;
	logic btn, busy, cb, rs;
	logic [1:0] st, stype;
	logic [3:0] rail;
	int err_count = 0, checked = 0, cbn = 0, rsn = 0;
	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (cb === 1'b1) cbn++;
	always @(posedge mclk_i) if (rs === 1'b1) rsn++;
	pbs_panel_model u_pbs_panel_model (.mclk_i(mclk_i), .go_i(go), .len_i(len), .btn_o(btn), .busy_o(busy));
	pbs_ctrl #(.SHORT_CYC(40), .FORCE_CYC(61)) u_pbs_ctrl (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce),
		.btn_i(btn), .btn_sleep_cfg_i(cfg), .btn_sleep_disk_i(sdisk), .os_off_req_i(off_req),
		.os_sleep_req_i(slp_req), .os_sleep_disk_i(os_disk), .wake_req_i(wake), .wake_en_i(wen),
		.sys_state_o(st), .sleep_type_o(stype), .rail_en_o(rail), .cold_boot_o(cb), .resume_o(rs));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wait_st(input logic [1:0] s);
		for (int i = 0; i < 200 && st !== s; i++) @(negedge mclk_i);
		check({2'h0, st}, {2'h0, s});
	endtask
	task automatic press(input logic [7:0] l, input logic [1:0] s);
		len = l;
		go = 1;
		@(negedge mclk_i);
		go = 0;
		for (int i = 0; i < 300 && busy; i++) @(negedge mclk_i);
		wait_st(s);
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		@(negedge mclk_i);
		s = 0;
	endtask
	task automatic give_verdict();
		$display("checked=%0d err_count=%0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_switch();
		check(rail, 4'h8);
		press(8'd10, 2'h1);
		check(rail, 4'hf);
		check(4'(cbn), 4'h1);
		cfg = 1;
		press(8'd10, 2'h2);
		check({stype, rail[1:0]}, 4'h5);
		check(rail, 4'h9);
		press(8'd10, 2'h1);
		check(4'(cbn), 4'h1);
		check(4'(rsn), 4'h1);
	endtask
	task automatic t_disk_wake();
		os_disk = 1;
		pulse(slp_req);
		wait_st(2'h2);
		check({stype, 2'h0}, 4'h8);
		check(rail, 4'h8);
		wake = 1;
		repeat (5) @(negedge mclk_i);
		check({2'h0, st}, 4'h2);
		wen = 1;
		@(negedge mclk_i);
		wake = 0;
		wait_st(2'h1);
		@(negedge mclk_i);
		check(4'(cbn), 4'h2);
		check(4'(rsn), 4'h2);
	endtask
	task automatic t_force();
		press(8'd10, 2'h2);
		press(8'd70, 2'h0);
		repeat (10) @(negedge mclk_i);
		check({2'h0, st}, 4'h0);
		cfg = 0;
		press(8'd10, 2'h1);
		press(8'd50, 2'h0);
		press(8'd10, 2'h1);
		press(8'd70, 2'h0);
		cfg = 1;
		sdisk = 1;
		press(8'd10, 2'h1);
		press(8'd60, 2'h2);
		check({stype, 2'h0}, 4'h8);
		sdisk = 0;
		press(8'd61, 2'h0);
		check(4'(rsn), 4'h2);
	endtask
	task automatic t_os();
		pulse(slp_req);
		repeat (3) @(negedge mclk_i);
		check({2'h0, st}, 4'h0);
		press(8'd10, 2'h1);
		ce = 0;
		off_req = 1;
		repeat (4) @(negedge mclk_i);
		check({2'h0, st}, 4'h1);
		ce = 1;
		wait_st(2'h0);
		off_req = 0;
		os_disk = 0;
		press(8'd10, 2'h1);
		pulse(slp_req);
		wait_st(2'h2);
		check({2'h0, stype}, 4'h1);
		check(rail, 4'h9);
	endtask
	initial begin
		repeat (16) @(negedge mclk_i);
		rst_i = 0;
		t_switch();
		t_disk_wake();
		t_force();
		t_os();
		give_verdict();
	end
	initial begin
		#60000;
		err_count++;
		give_verdict();
	end
endmodule // test_power_button_state_control
